// File: rtl/clock_gen_pkg.sv
// Shared constants and types for the CPU clock generation block
package clock_gen_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // System clock and timing
  localparam int MCLK_FREQ_KHZ = 25000; // System clock rate
  localparam int PLL_STARTUP_TIME_US = 1000; // Power-up to stable PLL clock
  localparam int PLL_LOCK_TIME_US = 1000; // Stable input to PLL lock
  localparam int PLL_STARTUP_CYCLES = (MCLK_FREQ_KHZ * PLL_STARTUP_TIME_US + 999) / 1000;
  localparam int PLL_LOCK_CYCLES = (MCLK_FREQ_KHZ * PLL_LOCK_TIME_US + 999) / 1000;
  localparam int PLL_BASE_FREQ_KHZ = 3125; // Free-running base, within 2 to 5 MHz
  localparam int PLL_BASE_HALF_INT = MCLK_FREQ_KHZ / (2 * PLL_BASE_FREQ_KHZ);
  localparam logic [2:0] PLL_BASE_HALF_CYCLES = 3'(PLL_BASE_HALF_INT);

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator monitor
  localparam logic [15:0] OSC_TIMEOUT_CYCLES = 16'h0100; // No rising edge this long: missing
  localparam logic [15:0] OSC_PERIOD_TOL = 16'h0002; // Allowed period jitter
  localparam logic [2:0] OSC_STABLE_PERIODS = 3'h4; // Matching periods for stable

  ////////////////////////////////////////////////////////////////////////////
  // Reset configuration byte
  localparam int CFG_MSB = 7; // Clock configuration field, high bit
  localparam int CFG_LSB = 5; // Clock configuration field, low bit
  localparam logic [7:0] RESET_CONFIG_RESET = 8'he0; // Default field 111
  localparam logic [2:0] CFG_PLL_X4 = 3'h7;
  localparam logic [2:0] CFG_PLL_X3 = 3'h6;
  localparam logic [2:0] CFG_PLL_X2 = 3'h5;
  localparam logic [2:0] CFG_PLL_X5 = 3'h4;
  localparam logic [2:0] CFG_DIRECT = 3'h3;
  localparam logic [2:0] CFG_PLL_X1P5 = 3'h2;
  localparam logic [2:0] CFG_PRESCALE = 3'h1;
  localparam logic [2:0] CFG_PLL_X2P5 = 3'h0;

  // PLL states
  typedef enum logic [1:0] {PLL_STARTUP, PLL_BASE, PLL_ACQUIRE, PLL_LOCKED} pll_state_e;

  // Twice the multiplication factor for a field value
  function automatic logic [3:0] pll_factor_x2(input logic [2:0] field);
    logic [3:0] f;
    f = 4'h8;
    unique case (field)
      CFG_PLL_X4: f = 4'h8;
      CFG_PLL_X3: f = 4'h6;
      CFG_PLL_X2: f = 4'h4;
      CFG_PLL_X5: f = 4'ha;
      CFG_PLL_X1P5: f = 4'h3;
      CFG_PLL_X2P5: f = 4'h5;
      default: f = 4'h2;
    endcase
    return f;
  endfunction : pll_factor_x2

endpackage : clock_gen_pkg

// File: rtl/osc_monitor_if.sv
// Interface carrying oscillator monitor results to the clock controller
`timescale 1ns/1ps
`default_nettype none
interface osc_monitor_if;
  logic rise; // Oscillator rising edge seen, pulse
  logic fall; // Oscillator falling edge seen, pulse
  logic [15:0] period; // Last period in system clocks
  logic missing; // No rising edge within timeout
  logic stable; // Periods repeat within tolerance
  modport mon (output rise, fall, period, missing, stable);
  modport user (input rise, fall, period, missing, stable);
endinterface : osc_monitor_if
`default_nettype wire

// File: rtl/osc_monitor.sv
// Oscillator edge detector, period meter and missing-clock watch
`timescale 1ns/1ps
`default_nettype none
module osc_monitor (
  input wire logic mclk_in, // System clock
  input wire logic rst_n_in, // Asynchronous reset, active low
  input wire logic osc_in, // Sampled oscillator level
  osc_monitor_if.mon mon_port // Results
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic prev; // Previous oscillator level
    logic [15:0] cnt; // Cycles since last rising edge
    logic [15:0] period; // Last measured period
    logic [2:0] match; // Consecutive matching periods
    logic rise; // Rising edge pulse
    logic fall; // Falling edge pulse
    logic missing; // Clock missing flag
    logic stable; // Clock stable flag
  } mon_s;

  mon_s mon_reg;
  mon_s mon_next;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    logic [15:0] meas;
    logic [15:0] diff;
    meas = mon_reg.cnt + 16'h0001;
    diff = (meas > mon_reg.period) ? meas - mon_reg.period : mon_reg.period - meas;
    mon_next = mon_reg;
    mon_next.prev = osc_in;
    mon_next.rise = osc_in & ~mon_reg.prev;
    mon_next.fall = ~osc_in & mon_reg.prev;
    if (osc_in && !mon_reg.prev)
    begin
      // New period ends here
      mon_next.cnt = 16'h0000;
      mon_next.period = meas;
      mon_next.missing = 1'b0;
      if (diff <= clock_gen_pkg::OSC_PERIOD_TOL && !mon_reg.missing)
      begin
        // Matching period, count toward stable
        if (mon_reg.match != clock_gen_pkg::OSC_STABLE_PERIODS)
        begin
          mon_next.match = mon_reg.match + 3'h1;
        end
      end
      else
      begin
        // Deviation: restart qualification
        mon_next.match = 3'h0;
      end
      mon_next.stable = (mon_next.match == clock_gen_pkg::OSC_STABLE_PERIODS);
    end
    else if (mon_reg.cnt >= clock_gen_pkg::OSC_TIMEOUT_CYCLES)
    begin
      // Edges stopped: flag missing clock
      mon_next.missing = 1'b1;
      mon_next.stable = 1'b0;
      mon_next.match = 3'h0;
    end
    else
    begin
      mon_next.cnt = mon_reg.cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mon_reg <= '0;
    end
    else
    begin
      mon_reg <= mon_next;
    end
  end

  // Results straight from the state register
  assign mon_port.rise = mon_reg.rise;
  assign mon_port.fall = mon_reg.fall;
  assign mon_port.period = mon_reg.period;
  assign mon_port.missing = mon_reg.missing;
  assign mon_port.stable = mon_reg.stable;

endmodule : osc_monitor
`default_nettype wire

// File: rtl/cpu_clock_generation_control.sv
// CPU clock generation: mode selection, PLL model, slow-down divider, RTC clock
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] Capture upper port byte at long reset end
// [R2] Field 011 passes oscillator straight through
// [R3] Field 001 divides oscillator by two
// [R4] PLL modes multiply oscillator by decoded factor
// [R5] Lock loss raises unlock interrupt request; code raises it in PLL modes only, none for fields 011 and 001
// [R6] Lost input drops PLL to base frequency
// [R7] Power-up: stable base clock after 1 ms
// [R8] Stable input: PLL locks within 1 ms
// [R9] Slow-down divides oscillator by 1 to 32; with field 001 code divides by 2 to 64
// [R10] Software picks basic or slow-down clock
// [R11] Emulation inverts top configuration bit
// [R12] RTC clock is prescaled oscillator, independent
// [R13] Both CPU clock edges flagged for use
// [R14] Oscillator failure in PLL mode: base clock
// [R15] Configuration held until next long reset
module cpu_clock_generation_control #(
  parameter int STARTUP_CYCLES = clock_gen_pkg::PLL_STARTUP_CYCLES, // Power-up wait
  parameter int LOCK_CYCLES = clock_gen_pkg::PLL_LOCK_CYCLES // Lock acquisition wait
) (
  input wire logic mclk_in, // System clock, 25 MHz
  input wire logic rst_n_in, // Power-up reset, asynchronous, active low
  input wire logic osc_in, // Oscillator clock level
  input wire logic long_reset_n_in, // Long hardware reset, active low
  input wire logic [7:0] port0_upper_byte_in, // Configuration straps
  input wire logic emulation_mode_in, // Emulation mode strap
  input wire logic slow_down_select_in, // 1: slow-down clock, 0: basic clock
  input wire logic [4:0] slow_down_divider_in, // Slow-down factor minus one
  output logic cpu_clk_out, // CPU clock
  output logic cpu_clk_rise_out, // CPU clock rising edge pulse
  output logic cpu_clk_fall_out, // CPU clock falling edge pulse
  output logic rtc_clk_out, // Real-time clock feed
  output logic [7:0] reset_config_high_byte_out, // Latched configuration byte
  output logic pll_stable_out, // PLL delivers a stable clock
  output logic pll_locked_out, // PLL locked to oscillator
  output logic pll_unlock_irq_out // Unlock interrupt request pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic lreset_prev; // Long reset level last cycle
    logic [7:0] cfg; // Reset configuration byte
    clock_gen_pkg::pll_state_e pll_state; // PLL state
    logic [15:0] timer; // Startup and lock timer
    logic [16:0] nco_acc; // Multiplier phase accumulator
    logic nco_clk; // Multiplied clock
    logic [2:0] base_cnt; // Base oscillator counter
    logic base_clk; // Base frequency clock
    logic [6:0] div_cnt; // Oscillator edge counter
    logic div_clk; // Divided oscillator clock
    logic rtc_clk; // Prescaled oscillator clock
    logic cpu_clk; // Selected CPU clock
    logic cpu_rise; // CPU clock rose
    logic cpu_fall; // CPU clock fell
    logic stable; // PLL output stable
    logic locked; // PLL locked
    logic irq; // Unlock request pulse
  } ctl_s;

  ctl_s ctl_reg;
  ctl_s ctl_next;

  osc_monitor_if mon_bus ();

  // Oscillator watch
  osc_monitor u_osc_monitor (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .osc_in(osc_in),
    .mon_port(mon_bus.mon)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    logic [2:0] field;
    logic pll_mode;
    logic prescale;
    logic osc_bad;
    logic [6:0] div_k;
    logic [16:0] sum;
    logic basic_clk;
    field = ctl_reg.cfg[clock_gen_pkg::CFG_MSB:clock_gen_pkg::CFG_LSB];
    pll_mode = (field != clock_gen_pkg::CFG_DIRECT) && (field != clock_gen_pkg::CFG_PRESCALE);
    prescale = (field == clock_gen_pkg::CFG_PRESCALE);
    osc_bad = mon_bus.missing | ~mon_bus.stable;
    sum = 17'h00000;
    div_k = 7'h02; // Prescale divisor unless slow-down picks another
    basic_clk = 1'b0; // Overwritten by the mode decode below
    ctl_next = ctl_reg;
    ctl_next.irq = 1'b0;

    // Configuration capture on release of long reset only
    ctl_next.lreset_prev = long_reset_n_in;
    if (!ctl_reg.lreset_prev && long_reset_n_in)
    begin
      ctl_next.cfg = {port0_upper_byte_in[7] ^ emulation_mode_in, port0_upper_byte_in[6:0]}; // [R1] [R11] [R15]
    end

    // Free-running base frequency
    if (ctl_reg.base_cnt >= clock_gen_pkg::PLL_BASE_HALF_CYCLES - 3'h1)
    begin
      ctl_next.base_cnt = 3'h0;
      ctl_next.base_clk = ~ctl_reg.base_clk; // [R6]
    end
    else
    begin
      ctl_next.base_cnt = ctl_reg.base_cnt + 3'h1;
    end

    // PLL lock sequence
    unique case (ctl_reg.pll_state)
      clock_gen_pkg::PLL_STARTUP:
      begin
        // Base clock settles after power-up
        if (ctl_reg.timer >= 16'(STARTUP_CYCLES - 1))
        begin
          ctl_next.pll_state = clock_gen_pkg::PLL_BASE;
          ctl_next.stable = 1'b1; // [R7]
          ctl_next.timer = 16'h0000;
        end
        else
        begin
          ctl_next.timer = ctl_reg.timer + 16'h0001;
        end
      end
      clock_gen_pkg::PLL_BASE:
      begin
        // Wait for a usable input clock
        if (!osc_bad)
        begin
          ctl_next.pll_state = clock_gen_pkg::PLL_ACQUIRE; // [R8]
          ctl_next.timer = 16'h0000;
        end
      end
      clock_gen_pkg::PLL_ACQUIRE:
      begin
        // Synchronising; drop back on any disturbance
        if (osc_bad)
        begin
          ctl_next.pll_state = clock_gen_pkg::PLL_BASE;
        end
        else if (ctl_reg.timer >= 16'(LOCK_CYCLES - 1))
        begin
          ctl_next.pll_state = clock_gen_pkg::PLL_LOCKED; // [R8]
          ctl_next.locked = 1'b1;
        end
        else
        begin
          ctl_next.timer = ctl_reg.timer + 16'h0001;
        end
      end
      clock_gen_pkg::PLL_LOCKED:
      begin
        // Input lost or unstable: unlock and fall back
        if (osc_bad)
        begin
          ctl_next.pll_state = clock_gen_pkg::PLL_BASE; // [R6] [R14]
          ctl_next.locked = 1'b0;
          ctl_next.irq = pll_mode; // [R5]
        end
      end
    endcase

    // Multiplier: toggle 2F times per oscillator period
    if (ctl_reg.pll_state == clock_gen_pkg::PLL_LOCKED && mon_bus.period != 16'h0000)
    begin
      sum = ctl_reg.nco_acc + {13'h0000, clock_gen_pkg::pll_factor_x2(field)};
      if (sum >= {1'b0, mon_bus.period})
      begin
        ctl_next.nco_acc = sum - {1'b0, mon_bus.period};
        ctl_next.nco_clk = ~ctl_reg.nco_clk; // [R4]
      end
      else
      begin
        ctl_next.nco_acc = sum;
      end
    end
    else
    begin
      ctl_next.nco_acc = 17'h00000;
    end

    // Edge divider: toggle every K oscillator edges
    if (slow_down_select_in)
    begin
      div_k = {2'h0, slow_down_divider_in} + 7'h01; // [R9]
      if (prescale)
      begin
        div_k = {div_k[5:0], 1'b0}; // [R9]
      end
    end
    else
    begin
      div_k = 7'h02; // [R3]
    end
    if (mon_bus.rise || mon_bus.fall)
    begin
      if (ctl_reg.div_cnt >= div_k - 7'h01)
      begin
        ctl_next.div_cnt = 7'h00;
        ctl_next.div_clk = ~ctl_reg.div_clk;
      end
      else
      begin
        ctl_next.div_cnt = ctl_reg.div_cnt + 7'h01;
      end
    end

    // RTC feed from prescaled oscillator, no mode dependence
    if (mon_bus.rise)
    begin
      ctl_next.rtc_clk = ~ctl_reg.rtc_clk; // [R12]
    end

    // Basic clock per configured mode
    if (pll_mode)
    begin
      basic_clk = ctl_next.locked ? ctl_next.nco_clk : ctl_next.base_clk; // [R4] [R14]
    end
    else if (prescale)
    begin
      basic_clk = ctl_next.div_clk; // [R3]
    end
    else
    begin
      basic_clk = osc_in; // [R2]
    end

    // Source selection and edge flags
    ctl_next.cpu_clk = slow_down_select_in ? ctl_next.div_clk : basic_clk; // [R10]
    ctl_next.cpu_rise = ctl_next.cpu_clk & ~ctl_reg.cpu_clk; // [R13]
    ctl_next.cpu_fall = ~ctl_next.cpu_clk & ctl_reg.cpu_clk; // [R13]
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctl_reg <= '0;
      ctl_reg.cfg <= clock_gen_pkg::RESET_CONFIG_RESET;
      ctl_reg.pll_state <= clock_gen_pkg::PLL_STARTUP;
    end
    else
    begin
      ctl_reg <= ctl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign cpu_clk_out = ctl_reg.cpu_clk;
  assign cpu_clk_rise_out = ctl_reg.cpu_rise;
  assign cpu_clk_fall_out = ctl_reg.cpu_fall;
  assign rtc_clk_out = ctl_reg.rtc_clk;
  assign reset_config_high_byte_out = ctl_reg.cfg;
  assign pll_stable_out = ctl_reg.stable;
  assign pll_locked_out = ctl_reg.locked;
  assign pll_unlock_irq_out = ctl_reg.irq;

endmodule : cpu_clock_generation_control
`default_nettype wire

// File: dv/osc_source.sv
// Behavioural oscillator source for the oscillator input
`timescale 1ns/1ps
`default_nettype none
module osc_source #(
  parameter int HALF_NS = 240 // Half period
) (
  input wire logic run_in, // High: oscillate
  output logic osc_out // Oscillator level
);
  ////////////////////////////////////////////////////////////////////////
  // Toggle with a phase offset from the system clock
  initial
  begin
    osc_out = 1'b0;
    #7;
    forever
    begin
      #(HALF_NS);
      osc_out = run_in ? ~osc_out : 1'b0; // Stopped source stands low
    end
  end
endmodule : osc_source
`default_nettype wire

// File: dv/cpu_clock_generation_control_chk.sv
// Port checks for the CPU clock generation block
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_generation_control_chk #(
  parameter int STARTUP_CYCLES = 20, // Power-up wait
  parameter int LOCK_CYCLES = 20 // Lock wait
) (
  input wire logic mclk_in, // System clock
  input wire logic rst_n_in, // Reset, active low
  input wire logic osc_in, // Oscillator
  input wire logic long_reset_n_in, // Long reset
  input wire logic [7:0] port0_upper_byte_in, // Straps
  input wire logic emulation_mode_in, // Emulation strap
  input wire logic slow_down_select_in, // Slow-down select
  input wire logic [4:0] slow_down_divider_in, // Slow-down factor
  input wire logic cpu_clk_out, // CPU clock
  input wire logic cpu_clk_rise_out, // Rise pulse
  input wire logic cpu_clk_fall_out, // Fall pulse
  input wire logic rtc_clk_out, // RTC feed
  input wire logic [7:0] reset_config_high_byte_out, // Latched byte
  input wire logic pll_stable_out, // PLL stable
  input wire logic pll_locked_out, // PLL locked
  input wire logic pll_unlock_irq_out // Unlock request
);
  int cyc; // Cycles since reset
  int idle; // Cycles since oscillator change
  logic osc_q; // Previous oscillator sample
  logic [2:0] fld; // Configuration field
  logic pll_mode; // Field picks a PLL factor
  assign fld = reset_config_high_byte_out[7:5];
  assign pll_mode = fld != 3'h3 && fld != 3'h1;
  ////////////////////////////////////////////////////////////////////////
  // Helper counters
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cyc <= 0;
      idle <= 0;
      osc_q <= 1'b0;
    end
    else
    begin
      cyc <= (cyc < 100000) ? cyc + 1 : cyc;
      idle <= (osc_in != osc_q) ? 0 : ((idle < 100000) ? idle + 1 : idle);
      osc_q <= osc_in;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // Base clock half period of four cycles
  sequence base_half;
    ##1 $stable(cpu_clk_out) [*3] ##1 $changed(cpu_clk_out);
  endsequence
  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_rise_pulse: assert property (cpu_clk_rise_out == (cpu_clk_out && !$past(cpu_clk_out)))
    else $error("rise pulse off");
  a_fall_pulse: assert property (cpu_clk_fall_out == (!cpu_clk_out && $past(cpu_clk_out)))
    else $error("fall pulse off");
  a_cfg_hold: assert property ($changed(reset_config_high_byte_out)
    |-> $past(long_reset_n_in) && !$past(long_reset_n_in, 2)) else $error("config moved");
  a_cfg_capture: assert property (cyc > 4 && $past(long_reset_n_in) && !$past(long_reset_n_in, 2)
    |-> reset_config_high_byte_out == {$past(port0_upper_byte_in[7]) ^ $past(emulation_mode_in),
    $past(port0_upper_byte_in[6:0])}) else $error("capture wrong");
  a_direct_path: assert property (fld == 3'h3 && $past(fld) == 3'h3 && !$past(slow_down_select_in)
    |-> cpu_clk_out == $past(osc_in)) else $error("direct path wrong");
  a_rtc_rise: assert property (cyc > 4 && $changed(rtc_clk_out) |-> $past(osc_in, 2) && !$past(osc_in, 3))
    else $error("rtc toggle wrong");
  a_stable_early: assert property (pll_stable_out |-> cyc >= STARTUP_CYCLES - 1)
    else $error("stable early");
  a_stable_kept: assert property (cyc > STARTUP_CYCLES + 1 |-> pll_stable_out)
    else $error("stable missing");
  a_lock_cause: assert property ($rose(pll_locked_out)
    |-> pll_stable_out && idle < 16 && !$past(pll_locked_out, LOCK_CYCLES)) else $error("bad lock");
  a_irq_cause: assert property (pll_unlock_irq_out |-> pll_mode && !pll_locked_out
    && ($past(pll_locked_out) || $past(pll_locked_out, 2))) else $error("stray irq");
  a_irq_on_loss: assert property ($fell(pll_locked_out) && pll_mode |-> ##[0:1] pll_unlock_irq_out)
    else $error("irq missing");
  a_base_clock: assert property (pll_mode && !pll_locked_out && !slow_down_select_in && idle > 300
    && $changed(cpu_clk_out) |-> base_half) else $error("base clock wrong");
endmodule : cpu_clock_generation_control_chk
bind cpu_clock_generation_control cpu_clock_generation_control_chk #(.STARTUP_CYCLES(STARTUP_CYCLES),
  .LOCK_CYCLES(LOCK_CYCLES)) u_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .osc_in(osc_in),
  .long_reset_n_in(long_reset_n_in), .port0_upper_byte_in(port0_upper_byte_in),
  .emulation_mode_in(emulation_mode_in), .slow_down_select_in(slow_down_select_in),
  .slow_down_divider_in(slow_down_divider_in), .cpu_clk_out(cpu_clk_out),
  .cpu_clk_rise_out(cpu_clk_rise_out), .cpu_clk_fall_out(cpu_clk_fall_out), .rtc_clk_out(rtc_clk_out),
  .reset_config_high_byte_out(reset_config_high_byte_out), .pll_stable_out(pll_stable_out),
  .pll_locked_out(pll_locked_out), .pll_unlock_irq_out(pll_unlock_irq_out));
`default_nettype wire

// File: dv/cpu_clock_generation_control_bench.sv
// Self-checking bench for the CPU clock generation block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module cpu_clock_generation_control_bench;
  typedef struct {logic [7:0] p0; logic emu; logic slow; logic [4:0] dv; logic [7:0] cfg; int rise;} row_s;
  logic mclk_in, rst_n_in, osc_in, long_reset_n_in, emulation_mode_in, slow_down_select_in;
  logic [7:0] port0_upper_byte_in, reset_config_high_byte_out; // Straps, latched byte
  logic [4:0] slow_down_divider_in; // Slow-down factor minus one
  logic cpu_clk_out, cpu_clk_rise_out, cpu_clk_fall_out, rtc_clk_out;
  logic pll_stable_out, pll_locked_out, pll_unlock_irq_out;
  logic osc_run, rq, seen; // Oscillator enable, rtc history, irq seen
  int n_fail, total_checks, nr, nf, nt; // Counters
  row_s rows [13]; // Mode table
  osc_source u_osc_source (.run_in(osc_run), .osc_out(osc_in));
  cpu_clock_generation_control #(.STARTUP_CYCLES(20), .LOCK_CYCLES(20)) u_cpu_clock_generation_control (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .osc_in(osc_in), .long_reset_n_in(long_reset_n_in),
    .port0_upper_byte_in(port0_upper_byte_in), .emulation_mode_in(emulation_mode_in),
    .slow_down_select_in(slow_down_select_in), .slow_down_divider_in(slow_down_divider_in),
    .cpu_clk_out(cpu_clk_out), .cpu_clk_rise_out(cpu_clk_rise_out), .cpu_clk_fall_out(cpu_clk_fall_out),
    .rtc_clk_out(rtc_clk_out), .reset_config_high_byte_out(reset_config_high_byte_out),
    .pll_stable_out(pll_stable_out), .pll_locked_out(pll_locked_out), .pll_unlock_irq_out(pll_unlock_irq_out));
  ////////////////////////////////////////////////////////////////////////
  // Clock, verdict and watchdog
  initial
  begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  task automatic stop_test;
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (60000) @(posedge mclk_in);
    n_fail++;
    stop_test();
  end
  // Count within two ticks
  function automatic logic near(input int a, input int b);
    return a >= b - 2 && a <= b + 2;
  endfunction : near
  // Count pulses over one hundred oscillator periods
  task automatic measure;
    nr = 0;
    nf = 0;
    nt = 0;
    rq = rtc_clk_out;
    repeat (1200)
    begin
      @(negedge mclk_in);
      nr += (cpu_clk_rise_out === 1'b1);
      nf += (cpu_clk_fall_out === 1'b1);
      nt += (rtc_clk_out === 1'b1 && rq === 1'b0);
      rq = rtc_clk_out;
    end
  endtask : measure
  // Strap capture through a long reset pulse
  task automatic apply(input int i);
    long_reset_n_in = 1'b0;
    port0_upper_byte_in = rows[i].p0;
    emulation_mode_in = rows[i].emu;
    slow_down_select_in = rows[i].slow;
    slow_down_divider_in = rows[i].dv;
    repeat (3) @(negedge mclk_in);
    long_reset_n_in = 1'b1;
    repeat (300) @(negedge mclk_in);
  endtask : apply
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rows = '{'{8'he0, 0, 0, 0, 8'he0, 400}, '{8'hc0, 0, 0, 0, 8'hc0, 300}, '{8'ha0, 0, 0, 0, 8'ha0, 200},
      '{8'h80, 0, 0, 0, 8'h80, 500}, '{8'h65, 0, 0, 0, 8'h65, 100}, '{8'h40, 0, 0, 0, 8'h40, 150},
      '{8'h3a, 0, 0, 0, 8'h3a, 50}, '{8'h00, 0, 0, 0, 8'h00, 250}, '{8'he0, 1, 0, 0, 8'h60, 100},
      '{8'h6f, 1, 0, 0, 8'hef, 400}, '{8'h60, 0, 1, 3, 8'h60, 25}, '{8'h20, 0, 1, 0, 8'h20, 50},
      '{8'he0, 0, 1, 31, 8'he0, 3}};
    {n_fail, total_checks} = 0;
    rst_n_in = 1'b0;
    long_reset_n_in = 1'b0;
    port0_upper_byte_in = 8'h00;
    emulation_mode_in = 1'b0;
    slow_down_select_in = 1'b0;
    slow_down_divider_in = 5'h00;
    osc_run = 1'b1;
    repeat (6) @(negedge mclk_in);
    `CHK(reset_config_high_byte_out, 8'he0)
    `CHK(pll_stable_out, 1'b0)
    rst_n_in = 1'b1;
    for (int i = 0; i < 13; i++)
    begin
      apply(i);
      `CHK(reset_config_high_byte_out, rows[i].cfg)
      `CHK(pll_locked_out, 1'b1)
      measure();
      `CHK(near(nr, rows[i].rise), 1'b1)
      // Slow clocks need not fit the window whole: falls judged on the table
      `CHK(near(nf, rows[i].rise), 1'b1)
      `CHK(near(nt, 50), 1'b1)
    end
    // Straps move without a long reset pulse
    port0_upper_byte_in = 8'h1f;
    repeat (20) @(negedge mclk_in);
    `CHK(reset_config_high_byte_out, 8'he0)
    // Oscillator loss in multiply mode
    apply(0);
    osc_run = 1'b0;
    seen = 1'b0;
    for (int j = 0; j < 600 && !seen; j++)
    begin
      @(negedge mclk_in);
      seen = (pll_unlock_irq_out === 1'b1);
    end
    `CHK(seen, 1'b1)
    `CHK(pll_locked_out, 1'b0)
    measure();
    `CHK(near(nr, 150), 1'b1)
    `CHK(pll_stable_out, 1'b1)
    osc_run = 1'b1;
    repeat (400) @(negedge mclk_in);
    `CHK(pll_locked_out, 1'b1)
    stop_test();
  end
endmodule : cpu_clock_generation_control_bench
`default_nettype wire
